// *** src/nvsp_pkg.sv ***
// Package of constants for the nonvolatile SRAM host controller.
// Assumes a 250 MHz system clock; all times are converted to cycles here.
package nvsp_pkg;

    // ------------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;

    // ------------------------------------------------------------------
    // Times as printed
    // ------------------------------------------------------------------
    localparam int READ_CYCLE_NS = 45;
    localparam int WRITE_PULSE_NS = 30;
    localparam int WRITE_CYCLE_NS = 45;
    localparam int SAVE_PULSE_NS = 15;
    localparam int RECALL_POWERUP_MS = 20;
    localparam int SAVE_MS = 8;
    localparam int SEQ_PROCESS_US = 100;
    localparam int SW_RECALL_US = 200;

    // ------------------------------------------------------------------
    // Least times round up to cycles
    // ------------------------------------------------------------------
    localparam int READ_CYCLES =
        (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_PULSE_CYCLES =
        (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_CYCLES =
        (WRITE_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SAVE_PULSE_CYCLES =
        (SAVE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Waits that the host allows the device (upper bounds)
    // ------------------------------------------------------------------
    localparam int RECALL_POWERUP_CYCLES =
        RECALL_POWERUP_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int SAVE_CYCLES = SAVE_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int SEQ_PROCESS_CYCLES =
        SEQ_PROCESS_US * (1000000 / CLK_PERIOD_PS);
    localparam int SW_RECALL_CYCLES =
        SW_RECALL_US * (1000000 / CLK_PERIOD_PS);

    // ------------------------------------------------------------------
    // Widths and command encodings
    // ------------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int SEQ_LEN = 6;
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_SOFT = 2'h2;
    localparam logic [1:0] CMD_HW_SAVE = 2'h3;

endpackage : nvsp_pkg

// *** src/nvsp_timer.sv ***
// Down counter that reports when a loaded count has run out.
// Assumes loads and the count come from the same clock domain.
`timescale 1ns/1ps
module nvsp_timer #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Load
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    // Status
    output logic o_done
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb begin
        next_count = count;
        if (i_load) begin
            next_count = i_count;
        end else if (count != '0) begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Done ignores the load, so a caller may reload on done without
    // closing a combinational loop through its own next-state logic.
    assign o_done = (count == '0);
endmodule : nvsp_timer

// *** src/nvsp_host.sv ***
// Host controller for an asynchronous nonvolatile SRAM with store pin.
// Assumes the memory sits on pins; pin inputs are synchronised here.
//
// Rules of the document
// R01 - Write strobe stays high through every read cycle.
// R02 - Device floats data if write strobe falls before chip select.
// R03 - Store/busy pin is left released during ordinary cycles.
// R04 - Address changes only while chip select is high.
// R05 - Clock register writes end by chip select, never by lane enables.
// R06 - Low lane enable falls before chip select and write strobe.
// R07 - Device finishes power-up recall within 20 ms.
// R08 - Device finishes a save within 8 ms.
// R09 - Device skips a save when nothing was written.
// R10 - Device keeps writes enabled briefly after a save starts.
// R11 - Device ignores cycles during save, recall and low supply.
// R12 - Device releases the store/busy pin to a weak pull-up.
// R13 - Device drives store/busy high at most 500 ns.
// R14 - Command sequence uses chip-select controlled reads.
// R15 - Six addresses read in order with write strobe high.
// R16 - Device acts on a command within 100 us.
// R17 - Software save and recall lock out I/O until finished.
// R18 - Sixth read data of a command sequence may be invalid.
// R19 - Hardware save request holds store/busy low at least 15 ns.
// R20 - Device re-enables outputs quickly when a save is skipped.
// R21 - Each command read lasts at least the read cycle time.
// R22 - Device holds store/busy low while a save runs.
`timescale 1ns/1ps
module nvsp_host #(
    parameter int RECALL_PU_CYC = nvsp_pkg::RECALL_POWERUP_CYCLES,
    parameter int SAVE_CYC = nvsp_pkg::SAVE_CYCLES,
    parameter int SEQ_CYC = nvsp_pkg::SEQ_PROCESS_CYCLES,
    parameter int SW_RECALL_CYC = nvsp_pkg::SW_RECALL_CYCLES,
    parameter logic [16:0] SEQ_ADDR0 = 17'h0_0000,
    parameter logic [16:0] SEQ_ADDR1 = 17'h0_0001,
    parameter logic [16:0] SEQ_ADDR2 = 17'h0_0002,
    parameter logic [16:0] SEQ_ADDR3 = 17'h0_0003,
    parameter logic [16:0] SEQ_ADDR4 = 17'h0_0004,
    parameter logic [16:0] SEQ_ADDR5 = 17'h0_0005
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // User command port
    input wire logic I_REQ_VALID,
    output logic O_REQ_READY,
    input wire logic [1:0] I_REQ_CMD,
    input wire logic [16:0] I_REQ_ADDR,
    input wire logic [15:0] I_REQ_WDATA,
    input wire logic [1:0] I_REQ_LANE,
    input wire logic I_REQ_CLOCK_REG,
    input wire logic I_REQ_SOFT_RECALL,
    output logic O_RSP_VALID,
    output logic [15:0] O_RSP_RDATA,
    output logic O_BUSY,
    // Memory pins
    output logic [16:0] O_MEM_ADDR,
    output logic O_CHIP_SELECT_N,
    output logic O_WRITE_STROBE_N,
    output logic O_OUTPUT_GATE_N,
    output logic O_LOW_LANE_ENABLE_N,
    output logic O_HIGH_LANE_ENABLE_N,
    input wire logic [15:0] I_MEM_DQ,
    output logic [15:0] O_MEM_DQ,
    output logic O_MEM_DQ_OE,
    input wire logic I_STORE_BUSY_N,
    output logic O_STORE_BUSY_N,
    output logic O_STORE_BUSY_OE
);
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_POWERUP = 8'b0000_0001,
        ST_IDLE = 8'b0000_0010,
        ST_SETUP = 8'b0000_0100,
        ST_STROBE = 8'b0000_1000,
        ST_GAP = 8'b0001_0000,
        ST_HW_PULSE = 8'b0010_0000,
        ST_WAIT_DEV = 8'b0100_0000,
        ST_SETTLE = 8'b1000_0000
    } nvsp_state_type;

    localparam int TW = 24;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    nvsp_state_type state, next_state;
    logic [16:0] addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic [1:0] cmd, next_cmd;
    logic [1:0] lane, next_lane;
    logic clock_reg, next_clock_reg;
    logic soft_recall, next_soft_recall;
    logic [2:0] step, next_step;
    logic [15:0] rdata, next_rdata;
    logic rsp, next_rsp;
    logic cs_n, next_cs_n;
    logic we_n, next_we_n;
    logic oe_n, next_oe_n;
    logic dq_oe, next_dq_oe;
    logic sb_oe, next_sb_oe;
    logic [3:0] phase, next_phase;
    logic tload;
    logic [TW-1:0] tcount;
    logic tdone;
    logic [15:0] dq_s1, dq_s2;
    logic sb_s1, sb_s2;
    logic pu_loaded;

    // Address of a given step of the command sequence.
    function automatic logic [16:0] seq_addr(input logic [2:0] s);
        case (s)
            3'd0: seq_addr = SEQ_ADDR0;
            3'd1: seq_addr = SEQ_ADDR1;
            3'd2: seq_addr = SEQ_ADDR2;
            3'd3: seq_addr = SEQ_ADDR3;
            3'd4: seq_addr = SEQ_ADDR4;
            default: seq_addr = SEQ_ADDR5;
        endcase
    endfunction : seq_addr

    nvsp_timer #(.WIDTH(TW)) u_timer (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_load(tload),
        .i_count(tcount),
        .o_done(tdone)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            dq_s1 <= 16'h0000;
            dq_s2 <= 16'h0000;
            sb_s1 <= 1'b1;
            sb_s2 <= 1'b1;
        end else begin
            dq_s1 <= I_MEM_DQ;
            dq_s2 <= dq_s1;
            sb_s1 <= I_STORE_BUSY_N;
            sb_s2 <= sb_s1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_addr = addr;
        next_wdata = wdata;
        next_cmd = cmd;
        next_lane = lane;
        next_clock_reg = clock_reg;
        next_soft_recall = soft_recall;
        next_step = step;
        next_rdata = rdata;
        next_rsp = 1'b0;
        next_cs_n = cs_n;
        next_we_n = we_n;
        next_oe_n = oe_n;
        next_dq_oe = dq_oe;
        next_sb_oe = sb_oe;
        next_phase = phase;
        tload = 1'b0;
        tcount = '0;
        case (state)
            ST_POWERUP: begin
                // Cycles would be ignored until the recall has run.
                if (!pu_loaded) begin
                    tload = 1'b1;
                    tcount = TW'(RECALL_PU_CYC); // see R07
                end else if (tdone) begin // see R07 R11
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (I_REQ_VALID) begin
                    next_cmd = I_REQ_CMD;
                    next_wdata = I_REQ_WDATA;
                    next_lane = I_REQ_LANE;
                    next_clock_reg = I_REQ_CLOCK_REG;
                    next_soft_recall = I_REQ_SOFT_RECALL;
                    next_step = 3'd0;
                    if (I_REQ_CMD == nvsp_pkg::CMD_HW_SAVE) begin
                        next_sb_oe = 1'b1; // see R19
                        tload = 1'b1;
                        tcount = TW'(nvsp_pkg::SAVE_PULSE_CYCLES);
                        next_state = ST_HW_PULSE;
                    end else begin
                        // Address moves only with chip select high.
                        next_addr = (I_REQ_CMD == nvsp_pkg::CMD_SOFT)
                            ? seq_addr(3'd0) : I_REQ_ADDR; // see R04
                        next_state = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // Lanes are set one cycle ahead of chip select.
                next_cs_n = 1'b0; // see R06 R05
                if (cmd == nvsp_pkg::CMD_WRITE) begin
                    next_we_n = 1'b0;
                    next_dq_oe = 1'b1;
                    tcount = TW'(nvsp_pkg::WRITE_PULSE_CYCLES);
                end else begin
                    next_we_n = 1'b1; // see R01 R14 R15
                    next_oe_n = 1'b0;
                    tcount = TW'(nvsp_pkg::READ_CYCLES); // see R21
                end
                tload = 1'b1;
                next_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (tdone) begin
                    // Chip select ends every cycle, also for clock writes.
                    next_cs_n = 1'b1; // see R05
                    next_we_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_rdata = dq_s2;
                    next_state = ST_GAP;
                end
            end
            ST_GAP: begin
                next_dq_oe = 1'b0;
                if (cmd == nvsp_pkg::CMD_SOFT
                    && step != 3'(nvsp_pkg::SEQ_LEN - 1)) begin
                    next_step = step + 3'd1;
                    next_addr = seq_addr(step + 3'd1); // see R15
                    next_state = ST_SETUP;
                end else if (cmd == nvsp_pkg::CMD_SOFT) begin
                    // Sixth read data is discarded as unreliable.
                    next_rdata = 16'h0000; // see R18
                    tload = 1'b1;
                    tcount = soft_recall
                        ? TW'(SEQ_CYC + SW_RECALL_CYC)
                        : TW'(SEQ_CYC + SAVE_CYC); // see R16 R17 R08
                    next_state = ST_WAIT_DEV;
                end else begin
                    next_rsp = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_HW_PULSE: begin
                if (tdone) begin
                    next_sb_oe = 1'b0; // see R03 R12
                    tload = 1'b1;
                    tcount = TW'(SAVE_CYC); // see R08 R09
                    next_phase = 4'd0;
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // Let the released pin settle through the synchroniser.
                next_phase = phase + 4'd1;
                if (phase == 4'd3) begin
                    next_state = ST_WAIT_DEV;
                end
            end
            ST_WAIT_DEV: begin
                // A busy pin low means a save runs; a skipped hardware save ends early.
                if (tdone || (cmd == nvsp_pkg::CMD_HW_SAVE && sb_s2)) begin
                    next_rsp = 1'b1; // see R22 R20 R11
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            state <= ST_POWERUP;
            addr <= 17'h0_0000;
            wdata <= 16'h0000;
            cmd <= 2'h0;
            lane <= 2'h0;
            clock_reg <= 1'b0;
            soft_recall <= 1'b0;
            step <= 3'h0;
            rdata <= 16'h0000;
            rsp <= 1'b0;
            cs_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            dq_oe <= 1'b0;
            sb_oe <= 1'b0;
            phase <= 4'h0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            wdata <= next_wdata;
            cmd <= next_cmd;
            lane <= next_lane;
            clock_reg <= next_clock_reg;
            soft_recall <= next_soft_recall;
            step <= next_step;
            rdata <= next_rdata;
            rsp <= next_rsp;
            cs_n <= next_cs_n;
            we_n <= next_we_n;
            oe_n <= next_oe_n;
            dq_oe <= next_dq_oe;
            sb_oe <= next_sb_oe;
            phase <= next_phase;
        end
    end

    // Marks that the power-up wait has been loaded once after reset.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            pu_loaded <= 1'b0;
        end else begin
            pu_loaded <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic lanes_on;
    assign lanes_on = (state != ST_IDLE && state != ST_POWERUP
        && state != ST_WAIT_DEV && state != ST_HW_PULSE
        && state != ST_SETTLE);
    assign O_REQ_READY = (state == ST_IDLE);
    assign O_BUSY = (state != ST_IDLE);
    assign O_RSP_VALID = rsp;
    assign O_RSP_RDATA = rdata;
    assign O_MEM_ADDR = addr;
    assign O_CHIP_SELECT_N = cs_n;
    assign O_WRITE_STROBE_N = we_n;
    assign O_OUTPUT_GATE_N = oe_n;
    // Clock register writes always use the low lane.
    assign O_LOW_LANE_ENABLE_N = !(lanes_on
        && (clock_reg || lane[0])); // see R06
    assign O_HIGH_LANE_ENABLE_N = !(lanes_on && !clock_reg && lane[1]);
    assign O_MEM_DQ = wdata;
    assign O_MEM_DQ_OE = dq_oe;
    assign O_STORE_BUSY_N = 1'b0;
    assign O_STORE_BUSY_OE = sb_oe;
endmodule : nvsp_host

// *** verif/nvsp_host_sva.sv ***
// Checker of the memory pin rules of the host controller.
// Assumes it is bound to nvsp_host and sees only its ports.
`timescale 1ns/1ps
module nvsp_chk (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // Memory pins
    input wire logic [16:0] O_MEM_ADDR,
    input wire logic O_CHIP_SELECT_N,
    input wire logic O_WRITE_STROBE_N,
    input wire logic O_OUTPUT_GATE_N,
    input wire logic O_LOW_LANE_ENABLE_N,
    input wire logic O_HIGH_LANE_ENABLE_N,
    input wire logic O_STORE_BUSY_OE
);
    // ------------------------------------------------------------------
    // Read strobe length
    // ------------------------------------------------------------------
    logic [7:0] rd_len;
    logic [7:0] next_rd_len;
    always_comb begin
        next_rd_len = O_OUTPUT_GATE_N ? 8'h00 : rd_len + 8'h01;
    end
    always_ff @(posedge I_SYS_CLK) begin
        rd_len <= I_RST_N ? next_rd_len : 8'h00;
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    a_we_high_read: assert property (
        !O_OUTPUT_GATE_N |-> O_WRITE_STROBE_N)
        else $error("write strobe low in a read");
    a_busy_free_cycle: assert property (
        !O_CHIP_SELECT_N |-> !O_STORE_BUSY_OE)
        else $error("store pin pulled in a cycle");
    a_addr_hold: assert property (
        $changed(O_MEM_ADDR) |-> O_CHIP_SELECT_N || O_WRITE_STROBE_N)
        else $error("address moved while selected");
    a_we_in_cs: assert property (
        !O_WRITE_STROBE_N |-> !O_CHIP_SELECT_N)
        else $error("write strobe outside chip select");
    a_lane_end: assert property (
        $rose(O_LOW_LANE_ENABLE_N) || $rose(O_HIGH_LANE_ENABLE_N)
        |-> $past(O_WRITE_STROBE_N) && $past(O_CHIP_SELECT_N))
        else $error("lane enable ended a cycle");
    a_lane_setup: assert property (
        $fell(O_WRITE_STROBE_N) |-> !$past(O_LOW_LANE_ENABLE_N)
        || !$past(O_HIGH_LANE_ENABLE_N))
        else $error("lane enable late for a write");
    a_read_length: assert property (
        $rose(O_OUTPUT_GATE_N) |-> rd_len >= 8'(nvsp_pkg::READ_CYCLES))
        else $error("read strobe too short");
    a_save_pulse: assert property (
        $rose(O_STORE_BUSY_OE) |-> O_STORE_BUSY_OE [*4])
        else $error("save request pulse too short");
endmodule : nvsp_chk

bind nvsp_host nvsp_chk nvsp_chk_i (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RST_N(I_RST_N),
    .O_MEM_ADDR(O_MEM_ADDR),
    .O_CHIP_SELECT_N(O_CHIP_SELECT_N),
    .O_WRITE_STROBE_N(O_WRITE_STROBE_N),
    .O_OUTPUT_GATE_N(O_OUTPUT_GATE_N),
    .O_LOW_LANE_ENABLE_N(O_LOW_LANE_ENABLE_N),
    .O_HIGH_LANE_ENABLE_N(O_HIGH_LANE_ENABLE_N),
    .O_STORE_BUSY_OE(O_STORE_BUSY_OE)
);

// *** verif/nvsp_mem_model.sv ***
// Behavioural nonvolatile SRAM on the controller's pins.
// Assumes pins are sampled on the system clock; keeps 256 words.
`timescale 1ns/1ps
module nvsp_mem_model #(
    parameter int SAVE_LEN = 60,
    parameter int LOCK_LEN = 30
) (
    // Clock
    input wire logic i_clk,
    // Memory pins
    input wire logic [16:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic i_lle_n,
    input wire logic i_hle_n,
    input wire logic [15:0] i_host_dq,
    input wire logic i_host_oe,
    input wire logic i_pin,
    // Bus and store pin pull
    output logic [15:0] o_bus,
    output logic o_pull
);
    localparam logic [16:0] SEQ [6] = '{17'h0_0000, 17'h0_0001,
        17'h0_0002, 17'h0_0003, 17'h0_0004, 17'h0_0005};
    logic [15:0] mem [256];
    logic [15:0] last = 16'h0000;
    logic [15:0] wdata;
    logic [7:0] waddr;
    logic [1:0] wlane;
    logic wr_prev = 1'b0;
    logic rd_prev = 1'b0;
    logic pin_prev = 1'b1;
    logic dirty = 1'b0;
    logic saving = 1'b0;
    int hold = 0;
    int seq = 0;
    logic drv;
    logic rd_now;
    // Power-up copy counts as done before the first access.
    initial begin
        foreach (mem[k]) mem[k] = 16'h0000;
    end
    assign drv = !i_cs_n && !i_oe_n && i_we_n && hold == 0;
    assign rd_now = !i_cs_n && i_we_n && !i_oe_n;
    // The pin is only pulled low; the pull-up sits on the wire.
    assign o_pull = saving;
    // A released bus shows the inverse of its last value, never a copy.
    always_comb begin
        o_bus = ~last;
        if (i_host_oe) begin
            o_bus = i_host_dq;
        end else if (drv) begin
            if (!i_lle_n) o_bus[7:0] = mem[i_addr[7:0]][7:0];
            if (!i_hle_n) o_bus[15:8] = mem[i_addr[7:0]][15:8];
        end
    end
    always @(posedge i_clk) begin
        last <= o_bus;
        pin_prev <= i_pin;
        rd_prev <= rd_now;
        if (hold > 0) hold <= hold - 1;
        else saving <= 1'b0;
        if (!i_cs_n && !i_we_n && hold == 0) begin
            wr_prev <= 1'b1;
            waddr <= i_addr[7:0];
            wdata <= o_bus;
            wlane <= {!i_hle_n, !i_lle_n};
            seq <= 0;
        end else if (wr_prev) begin
            wr_prev <= 1'b0;
            dirty <= 1'b1;
            if (wlane[0]) mem[waddr][7:0] <= wdata[7:0];
            if (wlane[1]) mem[waddr][15:8] <= wdata[15:8];
        end
        if (pin_prev && !i_pin && hold == 0 && dirty) begin
            saving <= 1'b1;
            hold <= SAVE_LEN;
            dirty <= 1'b0;
        end
        if (rd_now && !rd_prev) begin
            if (i_addr != SEQ[seq]) seq <= int'(i_addr == SEQ[0]);
            else if (seq == 5) begin
                seq <= 0;
                hold <= LOCK_LEN;
            end else seq <= seq + 1;
        end
    end
endmodule : nvsp_mem_model

// *** verif/tb_top.sv ***
// Self-checking bench of the host controller against a memory model.
// Assumes the checker binds itself; one 250 MHz clock.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic [16:0] addr = 17'h0_0000;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] lane = 2'h0;
    logic ckreg = 1'b0;
    logic recall = 1'b0;
    wire ready, rsp, busy, cs_n, we_n, oe_n, lle_n, hle_n;
    wire host_oe, sb_n, sb_oe, pull;
    wire [15:0] rdata, host_dq, bus;
    wire [16:0] maddr;
    wire pin = !(sb_oe && !sb_n) && !pull;
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 32'he252594e;
    logic [15:0] shadow [256];
    always #2 clk = ~clk;
    nvsp_host #(.RECALL_PU_CYC(50), .SAVE_CYC(200), .SEQ_CYC(50),
        .SW_RECALL_CYC(50)) nvsp_host_i (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_REQ_VALID(valid),
        .O_REQ_READY(ready), .I_REQ_CMD(cmd), .I_REQ_ADDR(addr),
        .I_REQ_WDATA(wdata), .I_REQ_LANE(lane), .I_REQ_CLOCK_REG(ckreg),
        .I_REQ_SOFT_RECALL(recall), .O_RSP_VALID(rsp),
        .O_RSP_RDATA(rdata), .O_BUSY(busy), .O_MEM_ADDR(maddr),
        .O_CHIP_SELECT_N(cs_n), .O_WRITE_STROBE_N(we_n),
        .O_OUTPUT_GATE_N(oe_n), .O_LOW_LANE_ENABLE_N(lle_n),
        .O_HIGH_LANE_ENABLE_N(hle_n), .I_MEM_DQ(bus), .O_MEM_DQ(host_dq),
        .O_MEM_DQ_OE(host_oe), .I_STORE_BUSY_N(pin),
        .O_STORE_BUSY_N(sb_n), .O_STORE_BUSY_OE(sb_oe));
    nvsp_mem_model nvsp_mem_model_i (.i_clk(clk), .i_addr(maddr),
        .i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_lle_n(lle_n),
        .i_hle_n(hle_n), .i_host_dq(host_dq), .i_host_oe(host_oe),
        .i_pin(pin), .o_bus(bus), .o_pull(pull));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [15:0] merge(input logic [15:0] old, nw,
        input logic [1:0] ln);
        merge = old;
        if (ln[0]) merge[7:0] = nw[7:0];
        if (ln[1]) merge[15:8] = nw[15:8];
    endfunction : merge
    // Waits are bounded; running out of either counts as a mismatch.
    task automatic do_req(input logic [1:0] c, input logic [16:0] a,
        input logic [15:0] d, input logic [1:0] ln, input logic ck, rc,
        output logic [15:0] rd, output int cyc);
        int n;
        n = 0;
        @(negedge clk);
        {cmd, addr, wdata, lane, ckreg, recall} = {c, a, d, ln, ck, rc};
        valid = 1'b1;
        while (ready !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        valid = 1'b0;
        cyc = 1;
        while (rsp !== 1'b1 && cyc < 2000) begin
            @(negedge clk);
            cyc++;
        end
        rd = rdata;
        if (n >= 2000 || cyc >= 2000) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : do_req
    task automatic rw(input logic [7:0] a, d_hi, d_lo, input logic [1:0] ln,
        input logic ck);
        logic [15:0] rd;
        int cyc;
        do_req(nvsp_pkg::CMD_WRITE, {9'h001, a}, {d_hi, d_lo}, ln, ck, 1'b0,
            rd, cyc);
        shadow[a] = merge(shadow[a], {d_hi, d_lo}, ck ? 2'b01 : ln);
        do_req(nvsp_pkg::CMD_READ, {9'h001, a}, 16'h0000, 2'b11, 1'b0,
            1'b0, rd, cyc);
        check("read data", rd, shadow[a]);
    endtask : rw
    initial begin
        logic [15:0] rd;
        int cyc;
        int i;
        foreach (shadow[k]) shadow[k] = 16'h0000;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        i = 0;
        while (ready !== 1'b1 && i < 2000) begin
            check("busy in power-up", {15'h0000, busy}, 16'h0001);
            @(negedge clk);
            i++;
        end
        check("power-up wait", 16'(i >= 50 && i < 2000), 16'h0001);
        for (i = 0; i < 24; i++) begin
            rw(8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                (i < 3) ? 2'(i + 1) : 2'b11, 1'b0);
        end
        $display("test random read write done");
        rw(8'h5a, 8'ha5, 8'h3c, 2'b10, 1'b1);
        rw(8'h5a, 8'h77, 8'h81, 2'b11, 1'b1);
        $display("test clock register write done");
        do_req(nvsp_pkg::CMD_HW_SAVE, 17'h0_0000, 16'h0000, 2'b11, 1'b0,
            1'b0, rd, cyc);
        check("dirty save long", 16'(cyc >= 60), 16'h0001);
        do_req(nvsp_pkg::CMD_HW_SAVE, 17'h0_0000, 16'h0000, 2'b11, 1'b0,
            1'b0, rd, cyc);
        check("clean save short", 16'(cyc < 60), 16'h0001);
        rw(8'h11, 8'hc3, 8'h96, 2'b11, 1'b0);
        $display("test hardware save done");
        for (i = 0; i < 2; i++) begin
            do_req(nvsp_pkg::CMD_SOFT, 17'h0_0000, 16'h0000, 2'b11, 1'b0,
                1'(i), rd, cyc);
            check("soft rdata", rd, 16'h0000);
            rw(8'h22, 8'($random(seed)), 8'h0f, 2'b11, 1'b0);
        end
        $display("test software sequence done");
        give_verdict();
    end
endmodule : tb_top
